// [rtl/omps_top.sv]
// Notes on behaviour
// - user_flag_select 0 makes spare flag an interrupt mask, 1 a user flag.
// - nmi_edge_select 0 requests NMI on falling edge (reset), 1 on rising.
// - standby_output_keep 0 floats address bus, selects and strobes in standby.
// - standby_output_keep 1 holds address, drives selects and strobes high in standby.
// - internal_ram_enable set by reset or by a software write; standby leaves it unchanged.
// - internal_ram_enable 0 disables on-chip RAM, 1 enables; reset value 1.
// - Modes 1 and 2 drive ports 1, 2, 5 as A19..A0, 1-Mbyte space.
// - Modes 1, 3, 5 start 8-bit; go 16-bit once any area is 16-bit.
// - Modes 2, 4 start 16-bit; go 8-bit only when all areas are 8-bit.
// - Modes 3, 4 always output A20; A23..A21 once release bits 7..5 are 0.
// - Mode 5 ports 1, 2, 5 start as inputs; address pin when direction bit 1.
// - Mode 5 port A gives A23..A20 once release bits 7..4 are 0.
// - Mode 6 is single-chip, all ports general I/O, 64-kbyte space.
// - Mode 7 is single-chip, all ports general I/O, 1-Mbyte space.
// - Modes 1..5 port 3 is D15..D8; port 4 is D7..D0 only in 16-bit mode.
// - Expanded modes split external space into eight separately sized areas.
// - RAM enable cleared in modes 1..5 sends RAM range to external bus.
`timescale 1ns/10ps
module omps_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] address_i,
    input  wire logic              read_i,
    input  wire logic              write_i,
    input  wire logic [31:0]       writedata_i,
    input  wire logic [3:0]        byteenable_i,
    output logic      [31:0]       readdata_o,
    output logic                   waitrequest_o,
    // Pins from the board
    input  wire logic [2:0]        mode_select_pins_i,
    input  wire logic              nmi_i,
    // From bus controller and power control, same clock
    input  wire logic              standby_i,
    input  wire logic [23:0]       bus_addr_i,
    input  wire logic [7:0]        chip_select_lines_i,
    input  wire logic              address_strobe_n_i,
    input  wire logic              read_strobe_n_i,
    input  wire logic              upper_write_strobe_n_i,
    input  wire logic              lower_write_strobe_n_i,
    // External bus pins
    output logic      [23:0]       addr_o,
    output logic      [23:0]       addr_oe_o,
    output logic      [7:0]        chip_select_lines_o,
    output logic                   chip_select_oe_o,
    output logic                   address_strobe_n_o,
    output logic                   read_strobe_n_o,
    output logic                   upper_write_strobe_n_o,
    output logic                   lower_write_strobe_n_o,
    output logic                   strobe_oe_o,
    // Port function selects, 1 = bus function
    output logic      [7:0]        port1_addr_o,
    output logic      [7:0]        port2_addr_o,
    output logic                   port3_data_o,
    output logic                   port4_data_o,
    output logic      [3:0]        port5_addr_o,
    output logic      [3:0]        porta_addr_o,
    // System status
    output logic                   bus_16bit_o,
    output logic      [7:0]        area_8bit_o,
    output logic      [1:0]        addr_space_o,
    output logic                   ram_enable_o,
    output logic                   ram_external_o,
    output logic                   user_flag_mode_o,
    output logic                   nmi_req_o,
    output logic                   irq_o
);
    import omps_pkg::*;

    if (ADDR_W < 6) begin : g_bad_addr_w
        $error("omps_top: ADDR_W must be at least 6");
    end

    typedef struct packed {
        logic [2:0]  md_s1;
        logic [2:0]  md_s2;
        logic [2:0]  mode;
        logic        init;
        logic        nmi_s1;
        logic        nmi_s2;
        logic        nmi_d;
        logic [3:0]  sysctl;
        logic [7:0]  awc;
        logic [3:0]  brc;
        logic [7:0]  p1d;
        logic [7:0]  p2d;
        logic [3:0]  p5d;
        logic [1:0]  ist;
        logic [1:0]  ien;
        logic        ack;
        logic [31:0] rdata;
        logic        wide;
        logic        irq;
        logic        ramx;
        logic        wreq;
        logic        nmi_req;
        logic [23:0] addr;
        logic [23:0] addr_oe;
        logic [7:0]  cs_n;
        logic        cs_oe;
        logic [3:0]  strb_n;
        logic        strb_oe;
        logic [7:0]  p1f;
        logic [7:0]  p2f;
        logic        p3f;
        logic        p4f;
        logic [3:0]  p5f;
        logic [3:0]  paf;
        logic [1:0]  space;
    } omps_state_t;

    omps_state_t s_r;
    omps_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]  offs;
    logic        expanded;
    logic        wide;
    logic        nmi_edge;
    logic        wr_go;
    logic        wr_b0;
    logic [1:0]  ev;
    logic [23:0] aoe;
    logic [7:0]  p1f;
    logic [7:0]  p2f;
    logic [3:0]  p5f;
    logic [3:0]  paf;
    logic [31:0] rd;

    assign offs = 8'(address_i);

    always_comb begin
        s_nxt    = s_r;
        expanded = (s_r.mode >= OMPS_MODE_1) && (s_r.mode <= OMPS_MODE_5);
        // Mode pins pass two flops before anything reads them
        s_nxt.md_s1  = mode_select_pins_i;
        s_nxt.md_s2  = s_r.md_s1;
        s_nxt.nmi_s1 = nmi_i;
        s_nxt.nmi_s2 = s_r.nmi_s1;
        s_nxt.nmi_d  = s_r.nmi_s2;

        // NMI edge per select bit
        if (s_r.sysctl[OMPS_NMI_EDGE_SELECT_BIT]) begin
            nmi_edge = s_r.nmi_s2 & ~s_r.nmi_d;
        end else begin
            nmi_edge = ~s_r.nmi_s2 & s_r.nmi_d;
        end
        s_nxt.nmi_req = nmi_edge;

        // Area widths come up per mode on the first cycle after reset
        if (!s_r.init) begin
            s_nxt.init = 1'b1;
            if (s_r.mode == OMPS_MODE_2 || s_r.mode == OMPS_MODE_4) begin
                s_nxt.awc = OMPS_AWC_ALL16;
            end else begin
                s_nxt.awc = OMPS_AWC_ALL8;
            end
        end

        // Bus answers one cycle after a request is seen
        wr_go       = write_i & s_r.ack;
        wr_b0       = wr_go & byteenable_i[0];
        s_nxt.ack   = (read_i | write_i) & ~s_r.ack & s_r.init;
        s_nxt.wreq  = ~s_nxt.ack;
        rd          = 32'h0;
        if (offs == OMPS_SYSCTL_OFS) begin
            rd[3:0] = s_r.sysctl;
        end else if (offs == OMPS_STATUS_OFS) begin
            rd[2:0] = s_r.mode;
            rd[3]   = s_r.wide;
            rd[5:4] = s_r.space;
            rd[6]   = expanded;
        end else if (offs == OMPS_AWC_OFS) begin
            rd[7:0] = s_r.awc;
        end else if (offs == OMPS_BRC_OFS) begin
            rd[7:4] = s_r.brc;
        end else if (offs == OMPS_P1DIR_OFS) begin
            rd[7:0] = s_r.p1d;
        end else if (offs == OMPS_P2DIR_OFS) begin
            rd[7:0] = s_r.p2d;
        end else if (offs == OMPS_P5DIR_OFS) begin
            rd[3:0] = s_r.p5d;
        end else if (offs == OMPS_IST_OFS) begin
            rd[1:0] = s_r.ist;
        end else if (offs == OMPS_IEN_OFS) begin
            rd[1:0] = s_r.ien;
        end
        if (s_nxt.ack) begin
            s_nxt.rdata = rd;
        end

        // Register writes; RAM enable is touched by software and reset only
        if (wr_b0) begin
            if (offs == OMPS_SYSCTL_OFS) begin
                s_nxt.sysctl = writedata_i[3:0];
            end else if (offs == OMPS_AWC_OFS) begin
                s_nxt.awc = writedata_i[7:0];
            end else if (offs == OMPS_BRC_OFS) begin
                s_nxt.brc = writedata_i[7:4];
            end else if (offs == OMPS_P1DIR_OFS) begin
                s_nxt.p1d = writedata_i[7:0];
            end else if (offs == OMPS_P2DIR_OFS) begin
                s_nxt.p2d = writedata_i[7:0];
            end else if (offs == OMPS_P5DIR_OFS) begin
                s_nxt.p5d = writedata_i[3:0];
            end else if (offs == OMPS_IEN_OFS) begin
                s_nxt.ien = writedata_i[1:0];
            end
        end

        // In expanded modes any 16-bit area means a 16-bit bus
        wide       = expanded && (s_nxt.awc != OMPS_AWC_ALL8);
        s_nxt.wide = wide;

        // Sticky events; a new event beats a clear in the same cycle
        ev                = '0;
        ev[OMPS_EV_NMI]   = nmi_edge;
        ev[OMPS_EV_WIDTH] = s_r.init & (wide != s_r.wide);
        if (wr_b0 && offs == OMPS_ICLR_OFS) begin
            s_nxt.ist = s_r.ist & ~writedata_i[1:0];
        end
        s_nxt.ist = s_nxt.ist | ev;
        s_nxt.irq = |(s_nxt.ist & s_nxt.ien);

        // Port functions per mode
        p1f = 8'h00;
        p2f = 8'h00;
        p5f = 4'h0;
        paf = 4'h0;
        s_nxt.space = OMPS_SPACE_16M;
        case (s_r.mode)
            OMPS_MODE_1, OMPS_MODE_2: begin
                p1f = 8'hff;
                p2f = 8'hff;
                p5f = 4'hf;
                s_nxt.space = OMPS_SPACE_1M;
            end
            OMPS_MODE_3, OMPS_MODE_4: begin
                p1f    = 8'hff;
                p2f    = 8'hff;
                p5f    = 4'hf;
                paf[3] = 1'b1;
                paf[2:0] = (s_r.brc[3:1] == 3'h0) ? 3'h7 : 3'h0;
            end
            OMPS_MODE_5: begin
                p1f = s_r.p1d;
                p2f = s_r.p2d;
                p5f = s_r.p5d;
                paf = (s_r.brc == 4'h0) ? 4'hf : 4'h0;
            end
            OMPS_MODE_6: begin
                s_nxt.space = OMPS_SPACE_64K;
            end
            default: begin
                s_nxt.space = OMPS_SPACE_1M;
            end
        endcase
        s_nxt.p1f = p1f;
        s_nxt.p2f = p2f;
        s_nxt.p5f = p5f;
        s_nxt.paf = paf;
        s_nxt.p3f = expanded;
        s_nxt.p4f = wide;
        s_nxt.ramx = ~s_nxt.sysctl[OMPS_INTERNAL_RAM_ENABLE_BIT] & expanded;

        // Port A pin 7 carries A20, pins 6..4 carry A23..A21
        aoe = {paf[2:0], paf[3], p5f, p2f, p1f};

        // Bus pins; single-chip modes never drive them
        if (!expanded) begin
            s_nxt.addr_oe = 24'h0;
            s_nxt.cs_oe   = 1'b0;
            s_nxt.strb_oe = 1'b0;
            s_nxt.cs_n    = 8'hff;
            s_nxt.strb_n  = 4'hf;
        end else if (standby_i) begin
            if (s_r.sysctl[OMPS_STANDBY_OUTPUT_KEEP_BIT]) begin
                s_nxt.addr_oe = aoe;
                s_nxt.cs_n    = 8'hff;
                s_nxt.strb_n  = 4'hf;
                s_nxt.cs_oe   = 1'b1;
                s_nxt.strb_oe = 1'b1;
            end else begin
                s_nxt.addr_oe = 24'h0;
                s_nxt.cs_oe   = 1'b0;
                s_nxt.strb_oe = 1'b0;
            end
        end else begin
            s_nxt.addr    = bus_addr_i;
            s_nxt.addr_oe = aoe;
            s_nxt.cs_n    = chip_select_lines_i;
            s_nxt.strb_n  = {address_strobe_n_i, read_strobe_n_i,
                             upper_write_strobe_n_i, lower_write_strobe_n_i};
            s_nxt.cs_oe   = 1'b1;
            s_nxt.strb_oe = 1'b1;
        end

        // Synchronous reset; mode pins keep shifting so the mode is latched in reset
        if (srst_i) begin
            s_nxt        = '0;
            s_nxt.md_s1  = mode_select_pins_i;
            s_nxt.md_s2  = s_r.md_s1;
            s_nxt.mode   = s_r.md_s2;
            s_nxt.sysctl = OMPS_SYSCTL_RST;
            s_nxt.awc    = OMPS_AWC_ALL8;
            s_nxt.brc    = 4'hf;
            s_nxt.cs_n   = 8'hff;
            s_nxt.strb_n = 4'hf;
            s_nxt.space  = OMPS_SPACE_16M;
            s_nxt.nmi_s1 = 1'b1;
            s_nxt.nmi_s2 = 1'b1;
            s_nxt.nmi_d  = 1'b1;
            s_nxt.wreq   = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign readdata_o             = s_r.rdata;
    assign waitrequest_o          = s_r.wreq;
    assign addr_o                 = s_r.addr;
    assign addr_oe_o              = s_r.addr_oe;
    assign chip_select_lines_o    = s_r.cs_n;
    assign chip_select_oe_o       = s_r.cs_oe;
    assign address_strobe_n_o     = s_r.strb_n[3];
    assign read_strobe_n_o        = s_r.strb_n[2];
    assign upper_write_strobe_n_o = s_r.strb_n[1];
    assign lower_write_strobe_n_o = s_r.strb_n[0];
    assign strobe_oe_o            = s_r.strb_oe;
    assign port1_addr_o           = s_r.p1f;
    assign port2_addr_o           = s_r.p2f;
    assign port3_data_o           = s_r.p3f;
    assign port4_data_o           = s_r.p4f;
    assign port5_addr_o           = s_r.p5f;
    assign porta_addr_o           = s_r.paf;
    assign bus_16bit_o            = s_r.wide;
    assign area_8bit_o            = s_r.awc;
    assign addr_space_o           = s_r.space;
    // Ram routing flags are plain copies of flops
    assign ram_enable_o           = s_r.sysctl[OMPS_INTERNAL_RAM_ENABLE_BIT];
    assign ram_external_o         = s_r.ramx;
    assign user_flag_mode_o       = s_r.sysctl[OMPS_UE_BIT];
    assign nmi_req_o              = s_r.nmi_req;
    assign irq_o                  = s_r.irq;

endmodule : omps_top

// [shared/omps_pkg.sv]
package omps_pkg;

    // Register byte offsets
    localparam logic [7:0] OMPS_SYSCTL_OFS = 8'h00;
    localparam logic [7:0] OMPS_STATUS_OFS = 8'h04;
    localparam logic [7:0] OMPS_AWC_OFS    = 8'h08;
    localparam logic [7:0] OMPS_BRC_OFS    = 8'h0c;
    localparam logic [7:0] OMPS_P1DIR_OFS  = 8'h10;
    localparam logic [7:0] OMPS_P2DIR_OFS  = 8'h14;
    localparam logic [7:0] OMPS_P5DIR_OFS  = 8'h18;
    localparam logic [7:0] OMPS_IST_OFS    = 8'h1c;
    localparam logic [7:0] OMPS_ICLR_OFS   = 8'h20;
    localparam logic [7:0] OMPS_IEN_OFS    = 8'h24;

    // system_control field positions
    localparam int OMPS_UE_BIT    = 3;
    localparam int OMPS_NMI_EDGE_SELECT_BIT = 2;
    localparam int OMPS_STANDBY_OUTPUT_KEEP_BIT  = 1;
    localparam int OMPS_INTERNAL_RAM_ENABLE_BIT  = 0;
    localparam logic [3:0] OMPS_SYSCTL_RST = 4'h9;

    // Interrupt status bits
    localparam int OMPS_EV_NMI   = 0;
    localparam int OMPS_EV_WIDTH = 1;
    localparam int OMPS_NEV      = 2;

    // Operating modes on the mode select pins
    localparam logic [2:0] OMPS_MODE_1 = 3'h1;
    localparam logic [2:0] OMPS_MODE_2 = 3'h2;
    localparam logic [2:0] OMPS_MODE_3 = 3'h3;
    localparam logic [2:0] OMPS_MODE_4 = 3'h4;
    localparam logic [2:0] OMPS_MODE_5 = 3'h5;
    localparam logic [2:0] OMPS_MODE_6 = 3'h6;
    localparam logic [2:0] OMPS_MODE_7 = 3'h7;

    // Area width reset values: a set bit means an 8-bit area
    localparam logic [7:0] OMPS_AWC_ALL8  = 8'hff;
    localparam logic [7:0] OMPS_AWC_ALL16 = 8'h00;

    // Address space size codes
    localparam logic [1:0] OMPS_SPACE_64K = 2'h0;
    localparam logic [1:0] OMPS_SPACE_1M  = 2'h1;
    localparam logic [1:0] OMPS_SPACE_16M = 2'h2;

endpackage : omps_pkg

// [tb/omps_ext_bus.sv]
`timescale 1ns/10ps
module omps_ext_bus (
    // Device pins
    input  wire logic [23:0] addr_i,
    input  wire logic [23:0] addr_oe_i,
    input  wire logic        strobe_oe_i,
    // Levels seen on the board
    output logic      [23:0] addr_wire_o,
    output logic             floating_o
);
    // No pull on the address lines: a released bit reads inverted
    assign addr_wire_o = ~(addr_i ^ addr_oe_i);
    assign floating_o  = ~|addr_oe_i & ~strobe_oe_i;
endmodule : omps_ext_bus

// [tb/omps_top_asserts.sv]
`timescale 1ns/10ps
module omps_top_asserts
    import omps_pkg::*;
(
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       srst_i,
    // Watched ports
    input wire logic [2:0] mode_select_pins_i,
    input wire logic       nmi_i,
    input wire logic [7:0] port1_addr_o,
    input wire logic [7:0] port2_addr_o,
    input wire logic       port3_data_o,
    input wire logic       port4_data_o,
    input wire logic [3:0] port5_addr_o,
    input wire logic [3:0] porta_addr_o,
    input wire logic       bus_16bit_o,
    input wire logic [7:0] area_8bit_o,
    input wire logic [1:0] addr_space_o,
    input wire logic       ram_enable_o,
    input wire logic       ram_external_o,
    input wire logic       nmi_req_o,
    input wire logic       irq_o
);
    logic [1:0]  up_r;
    logic        rdy;
    logic        expd;
    logic [23:0] sel;
    // Mode outputs settle one edge after release; checks start three edges after it
    always_ff @(posedge clk_i) begin
        up_r <= srst_i ? 2'h0 : up_r + {1'b0, up_r != 2'h3};
    end
    assign rdy  = (up_r == 2'h3);
    assign expd = rdy && (mode_select_pins_i inside {[3'h1:3'h5]});
    assign sel  = {port1_addr_o, port2_addr_o, port5_addr_o, porta_addr_o};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    addr_1m_a: assert property (rdy && mode_select_pins_i inside {3'h1, 3'h2}
        |-> sel == 24'hfffff0 && addr_space_o == OMPS_SPACE_1M) else $error("Mode 1/2 pins");
    chip_64k_a: assert property (rdy && mode_select_pins_i == OMPS_MODE_6 |->
        sel == 24'h0 && !port3_data_o && addr_space_o == OMPS_SPACE_64K) else $error("Mode 6");
    chip_1m_a: assert property (rdy && mode_select_pins_i == OMPS_MODE_7 |->
        sel == 24'h0 && !port4_data_o && addr_space_o == OMPS_SPACE_1M) else $error("Mode 7");
    data_port_a: assert property (expd |-> port3_data_o && port4_data_o == bus_16bit_o)
        else $error("Data port select");
    width_up_a: assert property (expd && area_8bit_o != 8'hff |-> ##[0:2] bus_16bit_o)
        else $error("Bus stuck at 8 bits");
    width_down_a: assert property (rdy && area_8bit_o == 8'hff |-> ##[0:2] !bus_16bit_o)
        else $error("Bus stuck at 16 bits");
    ram_init_a: assert property ($past(srst_i) |-> ram_enable_o)
        else $error("RAM enable not set by reset");
    ram_route_a: assert property (rdy && $stable(ram_enable_o) |->
        ram_external_o == (expd && !ram_enable_o)) else $error("RAM routing");
    nmi_src_a: assert property (nmi_req_o |-> $past(nmi_i, 2) != $past(nmi_i, 3) ||
        $past(nmi_i, 3) != $past(nmi_i, 4) || $past(nmi_i, 4) != $past(nmi_i, 5))
        else $error("NMI request without a pin edge");
    nmi_c: cover property (nmi_req_o);
    wide_c: cover property ($rose(bus_16bit_o));
    irq_c: cover property (irq_o);
endmodule : omps_top_asserts

bind omps_top omps_top_asserts chk_u (.clk_i, .srst_i, .mode_select_pins_i, .nmi_i,
    .port1_addr_o, .port2_addr_o, .port3_data_o, .port4_data_o, .port5_addr_o, .porta_addr_o,
    .bus_16bit_o, .area_8bit_o, .addr_space_o, .ram_enable_o, .ram_external_o, .nmi_req_o, .irq_o);

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
    import omps_pkg::*;
    logic        clk_i = 1'b0, srst_i = 1'b1, read_i = 1'b0, write_i = 1'b0, nmi_i = 1'b1;
    logic        standby_i = 1'b0, address_strobe_n_i = 1'b0, read_strobe_n_i = 1'b0;
    logic        upper_write_strobe_n_i = 1'b0, lower_write_strobe_n_i = 1'b0;
    logic [7:0]  address_i = 8'h00, chip_select_lines_i = 8'hfe;
    logic [31:0] writedata_i = 32'h0, readdata_o, d;
    logic [3:0]  byteenable_i = 4'h1, port5_addr_o, porta_addr_o;
    logic [2:0]  mode_select_pins_i = 3'h1;
    logic [23:0] bus_addr_i = 24'h0, addr_o, addr_oe_o, addr_wire;
    logic [7:0]  chip_select_lines_o, port1_addr_o, port2_addr_o, area_8bit_o;
    logic [1:0]  addr_space_o;
    logic        waitrequest_o, chip_select_oe_o, address_strobe_n_o, read_strobe_n_o;
    logic        upper_write_strobe_n_o, lower_write_strobe_n_o, strobe_oe_o, port3_data_o;
    logic        port4_data_o, bus_16bit_o, ram_enable_o, ram_external_o, user_flag_mode_o;
    logic        nmi_req_o, irq_o, floating;
    int          fails = 0, n_tests = 0, n_nmi = 0, cyc = 0;
    wire [19:0]  a20 = {port1_addr_o, port2_addr_o, port5_addr_o};
    wire [13:0]  ctl_hi = {chip_select_lines_o, address_strobe_n_o, read_strobe_n_o,
                           upper_write_strobe_n_o, lower_write_strobe_n_o, strobe_oe_o,
                           chip_select_oe_o};

    always #10 clk_i = ~clk_i;
    omps_top dut_u (.*);
    omps_ext_bus ext_u (.addr_i(addr_o), .addr_oe_i(addr_oe_o), .strobe_oe_i(strobe_oe_o),
                        .addr_wire_o(addr_wire), .floating_o(floating));

    always @(posedge clk_i) begin
        cyc++;
        if (nmi_req_o === 1'b1) n_nmi++;
        if (cyc == 3000) begin
            fails++;
            wrap_up();
        end
    end
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic boot(input logic [2:0] m);
        srst_i <= 1'b1;
        mode_select_pins_i <= m;
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : boot

    // Settle time after the answer covers the extra output register stage
    task automatic reg_io(input logic wr, input logic [7:0] a, input logic [31:0] v);
        address_i <= a;
        writedata_i <= v;
        write_i <= wr;
        read_i <= !wr;
        do @(posedge clk_i); while (waitrequest_o !== 1'b0);
        d = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : reg_io

    task automatic t_modes;
        logic       ex, w;
        logic [1:0] sp;
        for (int m = 1; m < 8; m++) begin
            boot(m[2:0]);
            ex = (m < 6);
            w = (m == 2 || m == 4);
            sp = (m == 6) ? 2'h0 : (m > 2 && m < 6) ? 2'h2 : 2'h1;
            chk("space", sp, addr_space_o);
            chk("addr", (m < 5) ? 32'hfffff : 32'h0, a20);
            chk("porta", (m == 3 || m == 4) ? 32'h8 : 32'h0, porta_addr_o);
            chk("data", {ex, ex & w}, {port3_data_o, port4_data_o});
            reg_io(1'b0, OMPS_AWC_OFS, 32'h0);
            chk("areas", w ? 32'h0 : 32'hff, d);
            chk("area_pins", w ? 32'h0 : 32'hff, area_8bit_o);
            reg_io(1'b0, OMPS_STATUS_OFS, 32'h0);
            chk("status", {ex, sp, ex & w, m[2:0]}, d);
            reg_io(1'b0, OMPS_SYSCTL_OFS, 32'h0);
            chk("sysctl", 32'h9, d);
        end
        $display("modes done");
    endtask : t_modes

    task automatic t_width;
        boot(OMPS_MODE_1);
        reg_io(1'b1, OMPS_AWC_OFS, 32'h7f);
        chk("any16", 32'h6, {bus_16bit_o, port4_data_o, irq_o});
        reg_io(1'b1, OMPS_IEN_OFS, 32'h2);
        reg_io(1'b0, OMPS_IST_OFS, 32'h0);
        chk("ist", 32'h2, d);
        chk("irq", 32'h1, irq_o);
        reg_io(1'b1, OMPS_ICLR_OFS, 32'h2);
        chk("irq_clr", 32'h0, irq_o);
        boot(OMPS_MODE_4);
        reg_io(1'b1, OMPS_AWC_OFS, 32'hfe);
        chk("one16", 32'h1, bus_16bit_o);
        reg_io(1'b1, OMPS_AWC_OFS, 32'hff);
        chk("all8", 32'h0, {bus_16bit_o, port4_data_o});
        $display("bus width done");
    endtask : t_width

    task automatic t_ext;
        boot(OMPS_MODE_3);
        reg_io(1'b1, OMPS_BRC_OFS, 32'h1f);
        chk("brc3", 32'hf, porta_addr_o);
        boot(OMPS_MODE_5);
        reg_io(1'b1, OMPS_BRC_OFS, 32'h0f);
        reg_io(1'b1, OMPS_P1DIR_OFS, 32'ha5);
        reg_io(1'b1, OMPS_P5DIR_OFS, 32'h3);
        chk("mode5", 32'hfa5003, {porta_addr_o, a20});
        $display("address ports done");
    endtask : t_ext

    task automatic t_sys;
        boot(OMPS_MODE_1);
        reg_io(1'b1, OMPS_SYSCTL_OFS, 32'h2);
        chk("flags", 32'h1, {user_flag_mode_o, ram_enable_o, ram_external_o});
        bus_addr_i <= 24'habcde;
        repeat (3) @(posedge clk_i);
        standby_i <= 1'b1;
        @(posedge clk_i);
        bus_addr_i <= 24'h12345;
        repeat (4) @(posedge clk_i);
        chk("held", 32'habcde, addr_wire[19:0]);
        chk("ctl", 32'h3fff, ctl_hi);
        chk("ram_sb", 32'h0, ram_enable_o);
        standby_i <= 1'b0;
        @(posedge clk_i);
        reg_io(1'b1, OMPS_SYSCTL_OFS, 32'h9);
        standby_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("float", 32'h1, floating);
        chk("cs_float", 32'h0, chip_select_oe_o);
        standby_i <= 1'b0;
        reg_io(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, d);
        $display("standby done");
    endtask : t_sys

    task automatic t_nmi;
        boot(OMPS_MODE_7);
        reg_io(1'b1, OMPS_IEN_OFS, 32'h1);
        n_nmi = 0;
        for (int i = 0; i < 4; i++) begin
            if (i == 2) reg_io(1'b1, OMPS_SYSCTL_OFS, 32'hd);
            nmi_i <= i[0];
            repeat (8) @(posedge clk_i);
            chk("nmi", (i < 3) ? 32'h1 : 32'h2, n_nmi);
        end
        chk("irq_n", 32'h1, irq_o);
        reg_io(1'b1, OMPS_ICLR_OFS, 32'h1);
        chk("irq_off", 32'h0, irq_o);
        $display("nmi done");
    endtask : t_nmi

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    initial begin
        t_modes();
        t_width();
        t_ext();
        t_sys();
        t_nmi();
        wrap_up();
    end
endmodule : tb
